// ### rtl/mcp_pkg.sv
package mcp_pkg;
  localparam int N_CH = 8;
  localparam int ENV_W = 8;
  localparam int NIB_W = 4;
  localparam int INC_W = 14;
  localparam int ADDR_W = 24;
  localparam int ALIGN_BITS = 4;
  localparam int AXI_AW = 8;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VOL = 8'h04;
  localparam logic [7:0] A_CHSEL = 8'h08;
  localparam logic [7:0] A_ENVL = 8'h0C;
  localparam logic [7:0] A_ENVH = 8'h10;
  localparam logic [7:0] A_DECMD = 8'h14;
  localparam logic [7:0] A_PTR = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_CHINFO = 8'h24;
  localparam logic [7:0] A_CHADDR = 8'h28;
  // field positions
  localparam int CTRL_MIX = 0;
  localparam int CTRL_AUD = 1;
  localparam int CTRL_PATH = 2;
  localparam int CTRL_CNT = 4;
  localparam int DEC_ADPCM = 0;
  localparam int DEC_TAIL = 1;
  localparam int CMD_LOAD_INC = 0;
  localparam int CMD_PLAY = 1;
  localparam int CMD_PLAY_IMM = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_IMM = 8;
  typedef enum logic [1:0] {PATH_PP = 2'h0, PATH_DAC = 2'h1, PATH_PWM = 2'h2} mcp_path_t;
  // reset values
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [3:0] VOL_RST = 4'h0;
  localparam logic [7:0] ENV_RST = 8'h00;
  localparam logic [13:0] INC_RST = 14'h0000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_NS = 25;
  localparam int RAMP_NS = 100000;
  localparam int RAMP_CYC = (RAMP_NS + CLK_NS - 1) / CLK_NS;
endpackage : mcp_pkg

// ### rtl/mcp_reg_if.sv
`timescale 1ns/10ps
interface mcp_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : mcp_reg_if

// ### rtl/mcp_axil.sv
`timescale 1ns/10ps
module mcp_axil
  import mcp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  mcp_reg_if.bus regs
);
  logic aw_q, w_q;
  logic fire;
  // each channel is held separately so address and data may come in either order
  assign awready = ~aw_q & ~bvalid;
  assign wready = ~w_q & ~bvalid;
  assign arready = ~rvalid;
  assign fire = aw_q & w_q & ~bvalid;
  assign regs.wr_en = fire;
  assign regs.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      regs.wr_addr <= 8'h00;
      regs.wr_data <= 32'h00000000;
      regs.wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        regs.wr_addr <= awaddr;
      end else if (fire) begin
        aw_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        regs.wr_data <= wdata;
        regs.wr_strb <= wstrb;
      end else if (fire) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (fire) begin
      bvalid <= 1'b1;
      bresp <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= regs.rd_data;
      rresp <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : mcp_axil

// ### rtl/mcp_ramp.sv
`timescale 1ns/10ps
module mcp_ramp
  import mcp_pkg::*;
#(
  parameter int RAMP_CYCLES = RAMP_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(RAMP_CYCLES + 1);
  typedef enum logic [2:0] {R_IDLE = 3'h1, R_RUN = 3'h2, R_DONE = 3'h4} mcp_ramp_t;
  mcp_ramp_t st_q;
  logic [CW-1:0] cnt_q;

  // dropping run at any point restarts the whole ramp next time
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      st_q <= R_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        R_IDLE: begin
          st_q <= R_RUN;
          cnt_q <= '0;
        end
        R_RUN: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CW'(RAMP_CYCLES - 1)) begin
            st_q <= R_DONE;
          end
        end
        R_DONE: st_q <= R_DONE;
        default: st_q <= R_IDLE;
      endcase
    end
  end

  // gated by run so a path or audio change never shows a stale ramp state
  assign busy = run && (st_q == R_RUN);
  assign done = run && (st_q == R_DONE);
endmodule : mcp_ramp

// ### rtl/mcp_melody_ctrl.sv
// Overview of operation
// - push-pull output ramps itself for 100 us
// - PWM output usable at once, no ramp
// - master volume has sixteen levels, 0 to 15
// - per-channel envelope from two nibbles, 256 levels
// - low nibble staged; high write commits both
// - head-only mode keeps tail waveform disabled
// - tail-only mode enables the tail waveform
// - per-channel PCM or ADPCM decode selection
// - play commands load start address, begin playback
// - two, four, six or eight active channels
// - each channel holds a 14-bit phase increment
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module mcp_melody_ctrl
  import mcp_pkg::*;
#(
  parameter int NCH = N_CH,
  parameter int RAMP_CYCLES = RAMP_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // output path
  output logic mixer_en,
  output logic audio_en,
  output logic [1:0] out_path,
  output logic out_ready,
  output logic ramp_active,
  output logic [3:0] master_vol,
  output logic [1:0] mix_attn,
  // per channel
  output logic [NCH-1:0] chan_active,
  output logic [NCH-1:0][ENV_W-1:0] ch_env,
  output logic [NCH-1:0][INC_W-1:0] ch_phase_increment,
  output logic [NCH-1:0] ch_adpcm,
  output logic [NCH-1:0] ch_tail_en,
  output logic [NCH-1:0][ADDR_W-1:0] ch_start_addr,
  output logic [NCH-1:0] ch_play,
  output logic [NCH-1:0] ch_playing
);
  localparam int SW = $clog2(NCH);

  mcp_reg_if regs ();

  logic mix_q, aud_q;
  mcp_path_t path_q;
  logic [1:0] cnt_q;
  logic [3:0] vol_q;
  logic [SW-1:0] chsel_q;
  logic [NIB_W-1:0] envl_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [3:0] act_n;
  logic ramp_run, ramp_busy, ramp_done;
  logic w0;
  logic [31:0] wd;
  logic w_ctrl, w_vol, w_chsel, w_envl, w_envh, w_dec, w_ptr, w_cmd;
  logic cmd_load_inc, cmd_go, cmd_stop;
  logic [ADDR_W-1:0] go_addr;

  mcp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .regs(regs)
  );

  // write decode; the byte 0 strobe gates every register except the pointer
  assign wd = regs.wr_data;
  assign w0 = regs.wr_en & regs.wr_strb[0];
  assign w_ctrl = w0 && regs.wr_addr == A_CTRL;
  assign w_vol = w0 && regs.wr_addr == A_VOL;
  assign w_chsel = w0 && regs.wr_addr == A_CHSEL;
  assign w_envl = w0 && regs.wr_addr == A_ENVL;
  assign w_envh = w0 && regs.wr_addr == A_ENVH;
  assign w_dec = w0 && regs.wr_addr == A_DECMD;
  assign w_ptr = regs.wr_en && regs.wr_addr == A_PTR;
  assign w_cmd = w0 && regs.wr_addr == A_CMD;
  assign cmd_load_inc = w_cmd & wd[CMD_LOAD_INC];
  assign cmd_go = w_cmd & (wd[CMD_PLAY] | wd[CMD_PLAY_IMM]);
  assign cmd_stop = w_cmd & wd[CMD_STOP];
  // immediate operand wins when both play bits are set
  assign go_addr = wd[CMD_PLAY_IMM] ? wd[CMD_IMM+:ADDR_W] : ptr_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mix_q <= 1'b0;
      aud_q <= 1'b0;
      path_q <= PATH_PP;
      cnt_q <= CNT_RST;
    end else if (w_ctrl) begin
      mix_q <= wd[CTRL_MIX];
      aud_q <= wd[CTRL_AUD];
      path_q <= mcp_path_t'(wd[CTRL_PATH+:2]);
      cnt_q <= wd[CTRL_CNT+:2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vol_q <= VOL_RST;
    end else if (w_vol) begin
      vol_q <= wd[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chsel_q <= '0;
    end else if (w_chsel) begin
      chsel_q <= wd[SW-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      envl_q <= '0;
    end else if (w_envl) begin
      envl_q <= wd[NIB_W-1:0];
    end
  end

  // six pointer nibbles, lowest nibble in bits 3:0; unstrobed bytes keep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= ADDR_RST;
    end else if (w_ptr) begin
      for (int b = 0; b < 3; b++) begin
        if (regs.wr_strb[b]) begin
          ptr_q[b*8+:8] <= wd[b*8+:8];
        end
      end
    end
  end

  // output path: only push-pull waits for its own ramp
  assign ramp_run = aud_q && path_q == PATH_PP;
  mcp_ramp #(
    .RAMP_CYCLES(RAMP_CYCLES)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ramp_run),
    .busy(ramp_busy),
    .done(ramp_done)
  );
  // dac is ready at once; its ramp is the program's business
  assign out_ready = aud_q && (path_q != PATH_PP || ramp_done);
  assign ramp_active = ramp_busy;
  assign mixer_en = mix_q;
  assign audio_en = aud_q;
  assign out_path = path_q;
  assign master_vol = vol_q;
  // mixer scales each channel down as more channels share the sum
  assign mix_attn = cnt_q;
  assign act_n = 4'({cnt_q, 1'b0}) + 4'h2;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic sel;
    assign sel = chsel_q == SW'(i);
    assign chan_active[i] = 4'(i) < act_n;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_env[i] <= ENV_RST;
      end else if (w_envh && sel) begin
        ch_env[i] <= {wd[NIB_W-1:0], envl_q};
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_adpcm[i] <= 1'b0;
        ch_tail_en[i] <= 1'b0;
      end else if (w_dec && sel) begin
        ch_adpcm[i] <= wd[DEC_ADPCM];
        ch_tail_en[i] <= wd[DEC_TAIL];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_phase_increment[i] <= INC_RST;
      end else if (cmd_load_inc && sel) begin
        ch_phase_increment[i] <= ptr_q[INC_W-1:0];
      end
    end

    // low address bits forced clear so a stray operand stays aligned
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_start_addr[i] <= ADDR_RST;
        ch_play[i] <= 1'b0;
      end else begin
        ch_play[i] <= cmd_go && sel && chan_active[i];
        if (cmd_go && sel && chan_active[i]) begin
          ch_start_addr[i] <= {go_addr[ADDR_W-1:ALIGN_BITS], ALIGN_BITS'(0)};
        end
      end
    end

    // a start in the same cycle as a stop keeps the channel playing
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ch_playing[i] <= 1'b0;
      end else if (ch_play[i]) begin
        ch_playing[i] <= 1'b1;
      end else if ((cmd_stop && sel) || !chan_active[i]) begin
        ch_playing[i] <= 1'b0;
      end
    end
  end

  // read decode
  always_comb begin
    regs.rd_ok = 1'b1;
    regs.rd_data = 32'h00000000;
    unique case (regs.rd_addr)
      A_CTRL: regs.rd_data = 32'({cnt_q, path_q, aud_q, mix_q});
      A_VOL: regs.rd_data = 32'(vol_q);
      A_CHSEL: regs.rd_data = 32'(chsel_q);
      A_ENVL: regs.rd_data = 32'(envl_q);
      A_ENVH: regs.rd_data = 32'(ch_env[chsel_q][ENV_W-1:NIB_W]);
      A_DECMD: regs.rd_data = 32'({ch_tail_en[chsel_q], ch_adpcm[chsel_q]});
      A_PTR: regs.rd_data = 32'(ptr_q);
      A_CMD: regs.rd_data = 32'h00000000;
      A_STAT: regs.rd_data = 32'({ch_playing[chsel_q], ramp_busy, out_ready});
      A_CHINFO: regs.rd_data = 32'({ch_phase_increment[chsel_q], ch_env[chsel_q]});
      A_CHADDR: regs.rd_data = 32'(ch_start_addr[chsel_q]);
      default: regs.rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (regs.wr_addr)
      A_CTRL, A_VOL, A_CHSEL, A_ENVL, A_ENVH, A_DECMD, A_PTR, A_CMD: regs.wr_ok = 1'b1;
      A_STAT, A_CHINFO, A_CHADDR: regs.wr_ok = 1'b1;
      default: regs.wr_ok = 1'b0;
    endcase
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [12:0] run_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ramp_run) begin
      run_cnt_q <= '0;
    end else if (run_cnt_q != 13'h1FFF) begin
      run_cnt_q <= run_cnt_q + 13'h0001;
    end
  end

  ramp_time_a: assert property (
    (ramp_run && $rose(out_ready)) |-> run_cnt_q == 13'(RAMP_CYCLES + 1))
    else $error("push-pull ready at wrong time");

  pwm_ready_a: assert property (
    (aud_q && path_q == PATH_PWM) |-> out_ready && !ramp_busy)
    else $error("pwm output not ready at once");

  vol_write_a: assert property (
    w_vol |=> master_vol == $past(wd[3:0]) ##1 $stable(master_vol) || $past(w_vol))
    else $error("master volume not taken");

  envh_commit_a: assert property (
    w_envh |=> ch_env[$past(chsel_q)] == {$past(wd[NIB_W-1:0]), $past(envl_q)})
    else $error("envelope not committed on high write");

  envl_only_a: assert property (
    (w_envl && !w_envh) |=> $stable(ch_env))
    else $error("envelope changed on low write");

  tail_mode_a: assert property (
    w_dec |=> ch_tail_en[$past(chsel_q)] == $past(wd[DEC_TAIL]))
    else $error("tail enable not set from mode");

  decode_fmt_a: assert property (
    w_dec |=> ch_adpcm[$past(chsel_q)] == $past(wd[DEC_ADPCM]))
    else $error("decode format not taken");

  imm_play_a: assert property (
    (cmd_go && wd[CMD_PLAY_IMM] && chan_active[chsel_q]) |=> ch_play[$past(chsel_q)]
      && ch_start_addr[$past(chsel_q)] == {$past(wd[CMD_IMM+ALIGN_BITS+:ADDR_W-ALIGN_BITS]), 4'h0}
      ##1 ch_playing[$past(chsel_q, 2)])
    else $error("immediate play failed");

  ptr_play_a: assert property (
    (cmd_go && !wd[CMD_PLAY_IMM] && chan_active[chsel_q]) |=>
      ch_start_addr[$past(chsel_q)] == {$past(ptr_q[ADDR_W-1:ALIGN_BITS]), 4'h0})
    else $error("pointer play address wrong");

  inactive_play_a: assert property (
    (ch_play & ~chan_active) == '0 && $countones(chan_active) == 2 * (int'(cnt_q) + 1))
    else $error("inactive channel started");

  phase_load_a: assert property (
    cmd_load_inc |=> ch_phase_increment[$past(chsel_q)] == $past(ptr_q[INC_W-1:0]))
    else $error("phase increment not loaded");
endmodule : mcp_melody_ctrl

// ### tb/mcp_melody_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module mcp_melody_ctrl_tb;
  import mcp_pkg::*;
  // short ramp keeps the run brief; expectations follow this value
  localparam int RAMP = 20;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic rd;
    logic [1:0] sel;
    logic [7:0] exp;
  } mcp_tb_row_t;
  logic aclk, aresetn;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, last_rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_resp;
  logic mixer_en, audio_en, out_ready, ramp_active;
  logic [1:0] out_path, mix_attn;
  logic [3:0] master_vol;
  logic [7:0] chan_active, ch_adpcm, ch_tail_en, ch_play, ch_playing;
  logic [7:0][ENV_W-1:0] ch_env;
  logic [7:0][INC_W-1:0] ch_phase_increment;
  logic [7:0][ADDR_W-1:0] ch_start_addr;
  int n_mismatch = 0;
  int n_compared = 0;
  int play_cnt = 0;
  int n;
  mcp_tb_row_t rows [0:11] = '{
    '{A_VOL, 32'h00000000, 1'b1, 2'h0, 8'h00}, '{A_VOL, 32'h0000000F, 1'b1, 2'h0, 8'h0F},
    '{A_VOL, 32'h00000009, 1'b1, 2'h0, 8'h09}, '{A_CTRL, 32'h00000001, 1'b1, 2'h1, 8'h03},
    '{A_CTRL, 32'h00000011, 1'b1, 2'h1, 8'h0F}, '{A_CTRL, 32'h00000021, 1'b1, 2'h1, 8'h3F},
    '{A_CTRL, 32'h00000031, 1'b1, 2'h1, 8'hFF}, '{A_CHSEL, 32'h00000003, 1'b1, 2'h3, 8'h03},
    '{A_DECMD, 32'h00000000, 1'b0, 2'h2, 8'h00}, '{A_DECMD, 32'h00000001, 1'b0, 2'h2, 8'h01},
    '{A_DECMD, 32'h00000002, 1'b0, 2'h2, 8'h02}, '{A_DECMD, 32'h00000003, 1'b0, 2'h2, 8'h03}};

  mcp_melody_ctrl #(.NCH(8), .RAMP_CYCLES(RAMP)) u_mcp_melody_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .mixer_en(mixer_en), .audio_en(audio_en), .out_path(out_path), .out_ready(out_ready),
    .ramp_active(ramp_active), .master_vol(master_vol), .mix_attn(mix_attn),
    .chan_active(chan_active), .ch_env(ch_env), .ch_phase_increment(ch_phase_increment),
    .ch_adpcm(ch_adpcm), .ch_tail_en(ch_tail_en), .ch_start_addr(ch_start_addr),
    .ch_play(ch_play), .ch_playing(ch_playing)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (ch_play[2] === 1'b1) play_cnt++;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // address and data offered together, each dropped at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic aw_done, w_done;
    int t;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (!w_done && wready === 1'b1) begin w_done = 1'b1; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin last_resp = bresp; bready <= 1'b0; break; end
    end
    if (t == 64) begin n_mismatch++; $display("[FAIL] write %0h no response", a); end
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (t = 0; t < 64; t++) begin
      @(posedge aclk);
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin last_rd = rdata; last_resp = rresp; rready <= 1'b0; break; end
    end
    if (t == 64) begin n_mismatch++; $display("[FAIL] read %0h no response", a); end
    #1;
  endtask : rd

  function automatic logic [7:0] port_of(input logic [1:0] s);
    case (s)
      2'h0: return {4'h0, master_vol};
      2'h1: return chan_active;
      2'h2: return {6'h00, ch_tail_en[3], ch_adpcm[3]};
      default: return {6'h00, mix_attn};
    endcase
  endfunction : port_of

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("[FAIL] watchdog expected finish seen hang");
    report_and_stop();
  end

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; awaddr = 8'h00; wvalid = 1'b0; wdata = 32'h00000000;
    wstrb = 4'h0; bready = 1'b0; arvalid = 1'b0; araddr = 8'h00; rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK("rst chan_active", 8'h03, chan_active)
    `CHK("rst env", 8'h00, ch_env[0])
    `CHK("rst vol", 4'h0, master_vol)
    `CHK("rst ready", 1'b0, out_ready)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK("row port", rows[i].exp, port_of(rows[i].sel))
      if (rows[i].rd) begin
        rd(rows[i].a);
        `CHK("row readback", rows[i].d, last_rd)
      end
    end
    // mixer settle time before audio setup
    repeat (32) @(posedge aclk);
    // staged low half, commit on high half
    wr(A_CHSEL, 32'h2);
    wr(A_ENVL, 32'h5);
    `CHK("env low only", 8'h00, ch_env[2])
    wr(A_ENVH, 32'hA);
    `CHK("env commit", 8'hA5, ch_env[2])
    `CHK("env other ch", 8'h00, ch_env[3])
    // increment from the rate formula, kept below 0x1000
    wr(A_PTR, 32'h0000038E);
    wr(A_CMD, 32'h1);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("phase load", 14'h038E, ch_phase_increment[2])
    rd(A_CHINFO);
    `CHK("chinfo", 32'h00038EA5, last_rd)
    wr(A_PTR, 32'h00FFFFFF);
    wr(A_CMD, 32'h1);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("phase 14 bit", 14'h3FFF, ch_phase_increment[2])
    // byte strobes: only the low two bytes land, upper byte keeps ff
    wr(A_PTR, 32'h00012500, 4'h3);
    wr(A_CMD, 32'h2);
    repeat (3) @(posedge aclk);
    #1;
    `CHK("play ptr addr", 24'hFF2500, ch_start_addr[2])
    `CHK("play ptr run", 1'b1, ch_playing[2])
    `CHK("play pulse", 1, play_cnt)
    wr(A_PTR, 32'h00012500);
    wr(A_CMD, 32'h2);
    repeat (3) @(posedge aclk);
    #1;
    `CHK("play nibble order", 24'h012500, ch_start_addr[2])
    wr(A_CMD, 32'h8);
    repeat (3) @(posedge aclk);
    #1;
    `CHK("stop", 1'b0, ch_playing[2])
    // immediate address beats the pointer form
    wr(A_CMD, 32'h00ABC006);
    repeat (3) @(posedge aclk);
    #1;
    `CHK("play imm addr", 24'h00ABC0, ch_start_addr[2])
    `CHK("play imm run", 1'b1, ch_playing[2])
    `CHK("play imm pulse", 3, play_cnt)
    rd(A_CHADDR);
    `CHK("chaddr", 32'h0000ABC0, last_rd)
    // push-pull ramp
    wr(A_CTRL, 32'h33);
    @(posedge aclk);
    #1;
    `CHK("pp not ready", 1'b0, out_ready)
    `CHK("pp ramping", 1'b1, ramp_active)
    n = 0;
    while (out_ready !== 1'b1 && n < 100) begin @(posedge aclk); #1; n++; end
    `CHK("pp ramp length", 1'b1, n >= RAMP - 4 && n <= RAMP + 1)
    `CHK("pp ramp over", 1'b0, ramp_active)
    wr(A_CTRL, 32'h3B);
    `CHK("pwm ready", 1'b1, out_ready)
    `CHK("pwm no ramp", 1'b0, ramp_active)
    `CHK("pwm path", 2'h2, out_path)
    wr(A_CTRL, 32'h37);
    `CHK("dac ready", 1'b1, out_ready)
    `CHK("dac no ramp", 1'b0, ramp_active)
    `CHK("dac path", 2'h1, out_path)
    wr(A_CTRL, 32'h35);
    `CHK("dac audio off", 1'b0, out_ready)
    `CHK("audio off", 1'b0, audio_en)
    `CHK("mixer stays", 1'b1, mixer_en)
    wr(A_CTRL, 32'h33);
    `CHK("pp restart", 1'b0, out_ready)
    `CHK("audio on", 1'b1, audio_en)
    `CHK("pp path", 2'h0, out_path)
    rd(A_STAT);
    `CHK("stat ramping", 32'h00000006, last_rd)
    // leaving push-pull mid-ramp must not leave a ramp showing
    wr(A_CTRL, 32'h3B);
    `CHK("pwm mid ramp", 1'b0, ramp_active)
    `CHK("pwm mid ready", 1'b1, out_ready)
    // unmapped and read-only places
    wr(8'h40, 32'h1);
    `CHK("unmapped wr", RESP_SLVERR, last_resp)
    rd(8'h40);
    `CHK("unmapped rd", RESP_SLVERR, last_resp)
    `CHK("unmapped data", 32'h0, last_rd)
    wr(A_STAT, 32'h7);
    `CHK("ro write", RESP_OKAY, last_resp)
    // channel leaves the active set: play stops and new play is ignored
    wr(A_CTRL, 32'h01);
    repeat (2) @(posedge aclk);
    #1;
    `CHK("inactive stop", 1'b0, ch_playing[2])
    wr(A_CHSEL, 32'h5);
    wr(A_CMD, 32'h00012004);
    repeat (3) @(posedge aclk);
    #1;
    `CHK("inactive play", 1'b0, ch_playing[5])
    // reset in mid-run, driven on the clock edge
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    `CHK("rerst env", 8'h00, ch_env[2])
    `CHK("rerst active", 8'h03, chan_active)
    `CHK("rerst phase", 14'h0000, ch_phase_increment[2])
    `CHK("rerst vol", 4'h0, master_vol)
    `CHK("rerst playing", 8'h00, ch_playing)
    report_and_stop();
  end
endmodule : mcp_melody_ctrl_tb
